// ### hdl/nfh_cfg.svh
// Constants for the page-flash host sequencer
`ifndef NFH_CFG_SVH
`define NFH_CFG_SVH
`define NFH_CLK_NS            5
`define NFH_CMD_READ          8'h00
`define NFH_CMD_READ_GO       8'h30
`define NFH_CMD_PROG          8'h80
`define NFH_CMD_PROG_GO       8'h10
`define NFH_CMD_CACHE_GO      8'h15
`define NFH_CMD_ERASE         8'h60
`define NFH_CMD_ERASE_GO      8'hd0
`define NFH_CMD_STATUS        8'h70
`define NFH_CMD_RESET         8'hff
`define NFH_OP_READ           3'h0
`define NFH_OP_PROG           3'h1
`define NFH_OP_CACHE          3'h2
`define NFH_OP_ERASE          3'h3
`define NFH_OP_STATUS         3'h4
`define NFH_OP_RESET          3'h5
`define NFH_PULSE_CYC         4'h5
`define NFH_ADL_NS            100
`define NFH_ADL_CYC           ((`NFH_ADL_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_WHR_NS            60
`define NFH_WHR_CYC           ((`NFH_WHR_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_PROG_MAX_US       700
`define NFH_PROG_MAX_CYC      (`NFH_PROG_MAX_US * 1000 / `NFH_CLK_NS)
`define NFH_ERASE_MAX_US      3000
`define NFH_ERASE_MAX_CYC     (`NFH_ERASE_MAX_US * 1000 / `NFH_CLK_NS)
`define NFH_BLK_COUNT         2048
`define NFH_USABLE_MIN        2008
`define NFH_NOP_MAX           4
`define NFH_FIFO_DEPTH        8
`endif

// ### hdl/nfh_pkg.sv
// Types for the page-flash host sequencer
package nfh_pkg;
   typedef enum logic [3:0]
   {
      NFH_IDLE, NFH_CMD1, NFH_ADDR, NFH_GAP, NFH_WDATA, NFH_CMD2, NFH_WAITB,
      NFH_TURN, NFH_RDATA, NFH_DONE
   } nfh_state_t;
endpackage

// ### hdl/nfh_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module nfh_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;
   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];
   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem_r[wr_r] <= in_data;
   end
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
            wr_r <= wr_r + 1'b1;
         if (pop)
            rd_r <= rd_r + 1'b1;
         cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

// ### hdl/nfh_host.sv
// Host sequencer driving the strobes and I/O bus of a page flash
// Notes on behaviour
// [R1] Each of command, address latch and select changes at most once per write pulse.
// [R2] At least 100 ns from last address write rise to first data write rise.
// [R3] Requests aimed at blocks marked bad are refused by the host; the host checks only program, cache and erase, reads pass.
// [R4] Block zero is assumed good; device guarantee, host relies on it.
// [R5] Up to 40 blocks may go bad; host tolerates growing bad blocks.
// [R6] At most four partial programs per page before erase; caller keeps count.
// [R7] After cache confirm the host waits for busy to release before more data.
// [R8] Program busy timeout allows the full 700 us.
// [R9] Bytes go out with select low, captured on the write strobe rising edge.
// [R10] Read and program send five address cycles, two column then three row.
// [R11] Host waits while ready/busy is low after program, erase or read.
// [R12] Page program is 80h, address, data, then 10h confirm.
// [R13] While write protect is low, program and erase requests are refused.
// [R14] Select is held high when idle so the device goes to standby.
`timescale 1ns/1ps
`include "nfh_cfg.svh"
module nfh_host
   import nfh_pkg::*;
#(
   parameter int PROG_TMO_CYC  = `NFH_PROG_MAX_CYC,
   parameter int ERASE_TMO_CYC = `NFH_ERASE_MAX_CYC
)
(
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [2:0]  req_op,
   input  wire logic [28:0] req_addr,
   input  wire logic [11:0] req_len,
   input  wire logic        req_blk_bad,
   input  wire logic        wp_allow,
   input  wire logic [7:0]  wr_data,
   input  wire logic        wr_valid,
   output logic             wr_ready,
   output logic [7:0]       rd_data,
   output logic             rd_valid,
   input  wire logic        rd_ready,
   output logic             done_pulse,
   output logic             err_refused,
   output logic             err_timeout,
   output logic             chip_sel_n,
   output logic             cmd_latch,
   output logic             addr_latch,
   output logic             write_strobe_n,
   output logic             read_strobe_n,
   output logic             write_prot_n,
   output logic [7:0]       io_out,
   output logic             io_oe,
   input  wire logic [7:0]  io_in,
   input  wire logic        ready_busy
);
   nfh_state_t  st_r;
   nfh_state_t  st_nxt;
   logic [2:0]  op_r;
   logic [28:0] addr_r;
   logic [11:0] len_r;
   logic [11:0] cnt_r;
   logic [2:0]  acnt_r;
   logic [3:0]  ph_r;
   logic [21:0] tmo_r;
   logic        ref_r;
   logic        tmo_err_r;
   logic        done_r;
   logic [7:0]  rbyte_r;
   logic        rbyte_v_r;
   logic        cs_n_r;
   logic        cle_r;
   logic        ale_r;
   logic        we_n_r;
   logic        re_n_r;
   logic [7:0]  io_r;
   logic        oe_r;
   logic [7:0]  f_data;
   logic        f_valid;
   logic        f_ready;
   logic        fin_ready;

   // ****************************************
   // Request decode
   // ****************************************
   wire is_write  = (req_op == `NFH_OP_PROG) || (req_op == `NFH_OP_CACHE)
                    || (req_op == `NFH_OP_ERASE);
   // Bad-block map is the caller's, so blocks that fail later are refused too
   wire refuse    = req_blk_bad && is_write || is_write && !wp_allow; // see [R3] see [R13] see [R5]
   // Block zero is never flagged by the caller, so only write protect can refuse it here; see [R4]
   wire take      = (st_r == NFH_IDLE) && req_valid;
   wire op_wr     = (op_r == `NFH_OP_PROG) || (op_r == `NFH_OP_CACHE);
   wire op_er     = (op_r == `NFH_OP_ERASE);
   wire op_rd     = (op_r == `NFH_OP_READ);
   wire one_cmd   = (op_r == `NFH_OP_STATUS) || (op_r == `NFH_OP_RESET);
   wire [2:0] n_addr = op_er ? 3'd3 : 3'd5; // see [R10]
   wire ph_end    = (ph_r == `NFH_PULSE_CYC);
   wire pulse_lo  = (ph_r < 4'd3);
   wire busy_lo   = !ready_busy;
   wire [21:0] tmo_lim = op_er ? 22'(ERASE_TMO_CYC) : 22'(PROG_TMO_CYC); // see [R8]
   wire last_byte = (cnt_r == len_r);
   wire [7:0] cmd1 = op_wr ? `NFH_CMD_PROG : op_er ? `NFH_CMD_ERASE :
                     (op_r == `NFH_OP_STATUS) ? `NFH_CMD_STATUS :
                     (op_r == `NFH_OP_RESET) ? `NFH_CMD_RESET : `NFH_CMD_READ;
   wire [7:0] cmd2 = (op_r == `NFH_OP_CACHE) ? `NFH_CMD_CACHE_GO :
                     op_er ? `NFH_CMD_ERASE_GO : op_wr ? `NFH_CMD_PROG_GO : `NFH_CMD_READ_GO;
   // Row-only addressing for erase starts at the third byte
   wire [2:0] abyte = op_er ? acnt_r + 3'd2 : acnt_r;
   wire [7:0] addr_byte = (abyte == 3'd0) ? addr_r[7:0] :
                          (abyte == 3'd1) ? {4'h0, addr_r[11:8]} :
                          (abyte == 3'd2) ? addr_r[19:12] :
                          (abyte == 3'd3) ? addr_r[27:20] : {7'h00, addr_r[28]};
   wire rd_phase  = (st_r == NFH_RDATA) || (st_r == NFH_TURN) || (st_r == NFH_DONE && op_r ==
                    `NFH_OP_STATUS);
   wire data_ok   = f_valid;

   assign req_ready   = (st_r == NFH_IDLE);
   assign wr_ready    = fin_ready;
   assign f_ready     = (st_r == NFH_WDATA) && ph_end;
   assign done_pulse  = done_r;
   assign err_refused = ref_r;
   assign err_timeout = tmo_err_r;
   assign rd_data     = rbyte_r;
   assign rd_valid    = rbyte_v_r;
   assign chip_sel_n  = cs_n_r;
   assign cmd_latch   = cle_r;
   assign addr_latch  = ale_r;
   assign write_strobe_n = we_n_r;
   assign read_strobe_n  = re_n_r;
   assign write_prot_n   = wp_allow;
   assign io_out      = io_r;
   assign io_oe       = oe_r;

   // ****************************************
   // Write data buffer
   // ****************************************
   nfh_fifo #(.WIDTH(8), .DEPTH(`NFH_FIFO_DEPTH)) u_fifo
   (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .in_data   (wr_data),
      .in_valid  (wr_valid),
      .in_ready  (fin_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_ready)
   );

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         NFH_IDLE:  if (req_valid && !refuse) st_nxt = NFH_CMD1;
         NFH_CMD1:  if (ph_end) st_nxt = one_cmd ? (op_r == `NFH_OP_STATUS ? NFH_TURN : NFH_WAITB)
                                                 : NFH_ADDR;
         NFH_ADDR:  if (ph_end && acnt_r == n_addr - 3'd1) st_nxt = op_wr ? NFH_GAP : NFH_CMD2;
         NFH_GAP:   if (cnt_r == 12'(`NFH_ADL_CYC)) st_nxt = NFH_WDATA;
         NFH_WDATA: if (ph_end && last_byte) st_nxt = NFH_CMD2;
         NFH_CMD2:  if (ph_end) st_nxt = NFH_WAITB;
         NFH_WAITB: if (tmo_r > 22'd4 && !busy_lo) st_nxt = op_rd ? NFH_TURN : NFH_DONE;
                    else if (tmo_r == tmo_lim) st_nxt = NFH_DONE;
         NFH_TURN:  if (cnt_r == 12'(`NFH_WHR_CYC)) st_nxt = NFH_RDATA;
         NFH_RDATA: if (ph_end && last_byte) st_nxt = NFH_DONE;
         NFH_DONE:  if (!rbyte_v_r) st_nxt = NFH_IDLE;
         default:   st_nxt = NFH_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         st_r <= NFH_IDLE;
      else
         st_r <= st_nxt;
   end

   // Phase counter paces each strobe pulse: low 2 cycles, high 4 cycles
   wire ph_run = (st_r == NFH_CMD1) || (st_r == NFH_ADDR) || (st_r == NFH_CMD2) ||
                 (st_r == NFH_WDATA && data_ok) ||
                 (st_r == NFH_RDATA && (!rbyte_v_r || ph_r != 4'h0));
   // A read pulse only starts once the last byte is taken, then runs to its end
   wire cnt_clr = (st_r != st_nxt);

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         ph_r <= 4'h0;
         acnt_r <= 3'd0;
         cnt_r <= 12'd0;
         tmo_r <= 22'd0;
      end
      else
      begin
         ph_r <= (ph_run && !ph_end) ? ph_r + 4'h1 : 4'h0;
         acnt_r <= (st_r == NFH_ADDR) ? acnt_r + {2'b00, ph_end} : 3'd0;
         tmo_r <= (st_r == NFH_WAITB) ? tmo_r + 22'd1 : 22'd0; // see [R7] see [R11]
         if (cnt_clr && st_nxt != NFH_RDATA && st_nxt != NFH_CMD2 || st_r == NFH_IDLE)
            cnt_r <= 12'd0;
         else if (st_r == NFH_GAP || st_r == NFH_TURN) // see [R2]
            cnt_r <= cnt_r + 12'd1;
         else if ((st_r == NFH_WDATA || st_r == NFH_RDATA) && ph_end)
            cnt_r <= cnt_r + 12'd1;
         if (cnt_clr && st_nxt == NFH_RDATA)
            cnt_r <= 12'd0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         op_r <= `NFH_OP_READ;
         addr_r <= 29'd0;
         len_r <= 12'd0;
         ref_r <= 1'b0;
         done_r <= 1'b0;
         tmo_err_r <= 1'b0;
      end
      else
      begin
         ref_r <= take && refuse;
         done_r <= (st_r == NFH_DONE) && (st_nxt == NFH_IDLE);
         tmo_err_r <= (st_r == NFH_WAITB) && (tmo_r == tmo_lim) && busy_lo;
         if (take)
         begin
            op_r <= req_op;
            addr_r <= req_addr;
            len_r <= (req_len == 12'd0) ? 12'd0 : req_len - 12'd1;
         end
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   // Latches settle before the pulse, so no control moves during a low phase
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         cs_n_r <= 1'b1;
         cle_r <= 1'b0;
         ale_r <= 1'b0;
         we_n_r <= 1'b1;
         re_n_r <= 1'b1;
         io_r <= 8'h00;
         oe_r <= 1'b0;
      end
      else
      begin
         cs_n_r <= (st_nxt == NFH_IDLE); // see [R14]
         cle_r <= (st_nxt == NFH_CMD1) || (st_nxt == NFH_CMD2); // see [R1]
         ale_r <= (st_nxt == NFH_ADDR);
         we_n_r <= !(ph_run && ph_r >= 4'h1 && pulse_lo && !rd_phase); // see [R9]
         re_n_r <= !(st_r == NFH_RDATA && ph_run && ph_r >= 4'h1 && pulse_lo);
         oe_r <= (st_r == NFH_CMD1) || (st_r == NFH_ADDR) || (st_r == NFH_CMD2) ||
                 (st_r == NFH_WDATA);
         io_r <= (st_r == NFH_CMD1) ? cmd1 : (st_r == NFH_CMD2) ? cmd2 : // see [R12]
                 (st_r == NFH_ADDR) ? addr_byte : f_data;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         rbyte_r <= 8'h00;
         rbyte_v_r <= 1'b0;
      end
      else if (st_r == NFH_RDATA && ph_r == 4'h3)
      begin
         rbyte_r <= io_in;
         rbyte_v_r <= 1'b1;
      end
      else if (rd_ready)
         rbyte_v_r <= 1'b0;
   end
endmodule

// ### testbench/nfh_host_asserts.sv
// Concurrent checks on the host sequencer's ports
`timescale 1ns/1ps
module nfh_host_asserts (
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [2:0]  req_op,
   input wire logic        req_blk_bad,
   input wire logic        wp_allow,
   input wire logic        err_refused,
   input wire logic [7:0]  rd_data,
   input wire logic        rd_valid,
   input wire logic        rd_ready,
   input wire logic        chip_sel_n,
   input wire logic        cmd_latch,
   input wire logic        addr_latch,
   input wire logic        write_strobe_n,
   input wire logic        read_strobe_n,
   input wire logic        write_prot_n,
   input wire logic        io_oe,
   input wire logic        ready_busy
);
   localparam int ADL_MIN = 19;
   logic        we_d;
   logic        armed_r;
   int unsigned gap_r;
   wire         wr_rise = write_strobe_n && !we_d;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // ****
   // Cycles since the last address byte
   // ****
   always_ff @(posedge clk_sys)
   begin
      we_d <= srst | write_strobe_n;
      if (srst || (wr_rise && addr_latch))
         gap_r <= 0;
      else if (gap_r < 1000)
         gap_r <= gap_r + 1;
      if (srst)
         armed_r <= 1'b0;
      else if (wr_rise)
         armed_r <= addr_latch;
   end
   chk_prot_follow: assert property (write_prot_n == wp_allow)
      else $error("protect pin differs from wp_allow");
   chk_refuse_req: assert property (req_valid && req_ready && req_op inside {3'h1, 3'h2, 3'h3}
      && (req_blk_bad || !wp_allow) |=> err_refused) else $error("forbidden request not refused");
   chk_idle_sel: assert property (req_ready |-> chip_sel_n)
      else $error("select low while idle");
   chk_pulse_hold: assert property (!write_strobe_n && !$past(write_strobe_n) |->
      $stable(cmd_latch) && $stable(addr_latch) && $stable(chip_sel_n))
      else $error("latch or select moved during write pulse");
   chk_wr_select: assert property (!write_strobe_n |->
      !chip_sel_n && io_oe && !(cmd_latch && addr_latch)) else $error("write pulse badly framed");
   chk_addr_gap: assert property (wr_rise && armed_r && !cmd_latch && !addr_latch |->
      gap_r >= ADL_MIN) else $error("data byte too soon after address");
   chk_busy_quiet: assert property (!ready_busy |-> write_strobe_n && read_strobe_n)
      else $error("strobe while device busy");
   chk_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("read byte dropped before taken");
endmodule

// ### testbench/nfh_flash_model.sv
// Behavioural page-flash device facing the host sequencer
`timescale 1ns/1ps
module nfh_flash_model (
   input  wire logic       clk_sys,
   input  wire logic       chip_sel_n,
   input  wire logic       cmd_latch,
   input  wire logic       addr_latch,
   input  wire logic       write_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic       write_prot_n,
   input  wire logic [7:0] io_out,
   output logic      [7:0] io_in,
   output logic            ready_busy
);
   int         busy_cyc = 40;
   int         bcnt = 0;
   logic [7:0] rix = 8'h00;
   logic [7:0] last = 8'h00;
   logic       we_d = 1'b1;
   logic       re_d = 1'b1;
   logic [9:0] log[$];
   wire        rd_on = !read_strobe_n && !chip_sel_n;
   wire        go = cmd_latch && io_out inside {8'h10, 8'h15, 8'hd0, 8'h30, 8'hff};
   // Released bus shows the inverse of the last byte, never a stale copy
   assign io_in = rd_on ? rix + 8'ha0 : ~last;
   assign ready_busy = !(bcnt > 0 && bcnt <= busy_cyc);
   always @(posedge clk_sys)
   begin
      we_d <= write_strobe_n;
      re_d <= read_strobe_n;
      if (bcnt > 0) bcnt <= bcnt - 1;
      if (rd_on) last <= io_in;
      if (read_strobe_n && !re_d && !chip_sel_n) rix <= rix + 8'h01;
      if (write_strobe_n && !we_d && !chip_sel_n)
      begin
         // Every block stays good here, block zero included
         log.push_back({cmd_latch, addr_latch, io_out});
         if (cmd_latch) rix <= 8'h00;
         if (go && (write_prot_n || io_out inside {8'h30, 8'hff})) bcnt <= busy_cyc + 2;
      end
   end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the page-flash host sequencer
`timescale 1ns/1ps
`include "nfh_cfg.svh"
module tb_top;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        req_valid = 1'b0;
   logic [2:0]  req_op = 3'h0;
   logic [28:0] req_addr = 29'h0;
   logic [11:0] req_len = 12'h1;
   logic        req_blk_bad = 1'b0;
   logic        wp_allow = 1'b1;
   logic [7:0]  wr_data = 8'h00;
   logic        wr_valid = 1'b0;
   logic        rd_ready = 1'b1;
   logic        req_ready, wr_ready, rd_valid, done_pulse, err_refused, err_timeout;
   logic        chip_sel_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n;
   logic        write_prot_n, io_oe, ready_busy, stall = 1'b0, s_tmo, s_ref;
   logic [7:0]  rd_data, io_out, io_in;
   logic [9:0]  exp_q[$];
   logic [7:0]  rd_q[$];
   int          bad_count = 0;
   int          num_checks = 0;
   nfh_host #(.PROG_TMO_CYC(200), .ERASE_TMO_CYC(600)) DUT (.*);
   nfh_flash_model flash (.*);
   initial forever #2.5 clk_sys = ~clk_sys;
   // Read side stalls every other cycle when asked to
   always @(posedge clk_sys) rd_ready <= stall ? ~rd_ready : 1'b1;
   always @(negedge clk_sys) if (rd_valid === 1'b1 && rd_ready === 1'b1) rd_q.push_back(rd_data);
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic push(input int n);
      @(posedge clk_sys);
      for (int i = 0; i < n; i++)
      begin
         wr_data <= 8'h5a ^ i[7:0];
         wr_valid <= 1'b1;
         do @(negedge clk_sys); while (wr_ready !== 1'b1);
         @(posedge clk_sys);
      end
      wr_valid <= 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic run(input logic [2:0] op, input logic [28:0] a, input int n, input logic bad);
      int t;
      t = 0;
      s_tmo = 1'b0;
      s_ref = 1'b0;
      flash.log.delete();
      rd_q.delete();
      exp_q.delete();
      while (req_ready !== 1'b1) @(negedge clk_sys);
      @(posedge clk_sys);
      req_op <= op;
      req_addr <= a;
      req_len <= n[11:0];
      req_blk_bad <= bad;
      req_valid <= 1'b1;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      do
      begin
         @(negedge clk_sys);
         t++;
         s_tmo |= err_timeout;
         s_ref |= err_refused;
      end
      while (done_pulse !== 1'b1 && err_refused !== 1'b1 && t < 4000);
      chk("op finished", 1, t < 4000);
      while (ready_busy !== 1'b1 && t < 5000) @(negedge clk_sys) t++;
   endtask
   task automatic exp_addr(input logic [28:0] a, input bit col);
      if (col) exp_q.push_back({2'b01, a[7:0]});
      if (col) exp_q.push_back({2'b01, 4'h0, a[11:8]});
      exp_q.push_back({2'b01, a[19:12]});
      exp_q.push_back({2'b01, a[27:20]});
      exp_q.push_back({2'b01, 7'h00, a[28]});
   endtask
   task automatic cmp_log(input logic [7:0] go);
      exp_q.push_back({2'b10, go});
      chk("bus byte count", exp_q.size(), flash.log.size());
      foreach (exp_q[i]) chk("bus byte", exp_q[i], i < flash.log.size() ? flash.log[i] : 10'h0);
   endtask
   task automatic t_prog(input logic [2:0] op, input logic [7:0] go, input int n);
      logic [28:0] a;
      a = 29'h1abcd123 ^ 29'(n);
      push(n);
      chk("fifo ready", n < 8, wr_ready);
      run(op, a, n, 1'b0);
      exp_q.push_back({2'b10, `NFH_CMD_PROG});
      exp_addr(a, 1);
      for (int i = 0; i < n; i++) exp_q.push_back({2'b00, 8'h5a ^ i[7:0]});
      cmp_log(go);
      chk("no timeout", 0, s_tmo);
      chk("fifo drained", 1, wr_ready);
      $display("test program op %0d done", op);
   endtask
   task automatic t_erase_refuse();
      run(`NFH_OP_PROG, 29'h40000, 1, 1'b1);
      chk("bad block refused", 1, s_ref);
      chk("no bus bytes", 0, flash.log.size());
      wp_allow <= 1'b0;
      run(`NFH_OP_ERASE, 29'h40000, 1, 1'b0);
      chk("protect refused", 1, s_ref);
      chk("protect pin", 0, write_prot_n);
      wp_allow <= 1'b1;
      run(`NFH_OP_ERASE, 29'h1fedc000, 1, 1'b0);
      exp_q.push_back({2'b10, `NFH_CMD_ERASE});
      exp_addr(29'h1fedc000, 0);
      cmp_log(`NFH_CMD_ERASE_GO);
      $display("test erase and refusal done");
   endtask
   task automatic t_read();
      stall = 1'b1;
      run(`NFH_OP_READ, 29'h0abc5678, 4, 1'b0);
      exp_q.push_back({2'b10, `NFH_CMD_READ});
      exp_addr(29'h0abc5678, 1);
      cmp_log(`NFH_CMD_READ_GO);
      chk("read count", 4, rd_q.size());
      foreach (rd_q[i]) chk("read byte", 8'ha0 + i, rd_q[i]);
      stall = 1'b0;
      run(`NFH_OP_STATUS, 29'h0, 1, 1'b0);
      cmp_log(`NFH_CMD_STATUS);
      run(`NFH_OP_RESET, 29'h0, 1, 1'b0);
      cmp_log(`NFH_CMD_RESET);
      $display("test read status reset done");
   endtask
   task automatic t_tmo();
      flash.busy_cyc = 400;
      push(1);
      run(`NFH_OP_PROG, 29'h2000, 1, 1'b0);
      chk("timeout flagged", 1, s_tmo);
      flash.busy_cyc = 40;
      $display("test timeout done");
   endtask
   initial
   begin
      repeat (8) @(posedge clk_sys);
      srst <= 1'b0;
      @(negedge clk_sys);
      chk("idle select", 1, chip_sel_n);
      chk("idle ready", 1, req_ready);
      // Both program tests hit the same page, twice in all, well inside the partial program limit
      t_prog(`NFH_OP_PROG, `NFH_CMD_PROG_GO, 8);
      t_prog(`NFH_OP_CACHE, `NFH_CMD_CACHE_GO, 2);
      t_erase_refuse();
      t_read();
      t_tmo();
      summarize();
   end
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      bad_count++;
      summarize();
   end
endmodule
bind nfh_host nfh_host_asserts chk (.*);
